//--- hdl/ovc_pkg.sv
// Constants and types shared by the output value conditioning block
package ovc_pkg;
  // Values are in tenths of a percent, 0 to 1000
  localparam int PCT_W = 10;
  localparam logic [9:0] PCT_FULL = 10'h03e8;
  localparam logic [9:0] CEIL_RESET = 10'h03e8;
  localparam logic [9:0] FLOOR_RESET = 10'h0000;
  localparam logic [9:0] BASE_RESET = 10'h0000;
  localparam logic [9:0] DUTY_RESET = 10'h03e8;
  // Ramp times in tenths of a second, 0 to 999
  localparam logic [9:0] RAMP_UP_RESET = 10'h0005;
  localparam logic [9:0] RAMP_DOWN_RESET = 10'h0000;
  localparam int CLK_HZ = 100_000_000;
  localparam int RAMP_UNIT_NS = 100_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  // One 0.1 % step per tenth-second of ramp time spans the full range
  localparam int RAMP_TICK_CYC = RAMP_UNIT_NS / CLK_PERIOD_NS / 1000;
  // Current in tenths of an ampere, 0 to 660
  localparam logic [9:0] CUR_CEIL_RESET = 10'h0294;
  localparam int CUR_LIMIT_MS = 500;
  localparam int CUR_STEP_CYC = 100_000;
  // Run time counted in tenths of kilohours (360 000 s each)
  localparam logic [9:0] RUN_SET_RESET = 10'h0000;
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_LVL1 = 2'h1;
  localparam logic [1:0] ACT_LVL2 = 2'h2;
  localparam logic [7:0] BURN_THR_RESET = 8'h64;
  localparam logic [9:0] BURN_PERSIST_RESET = 10'h0096;
  localparam logic CTRL_PHASE = 1'b0;
  localparam logic CTRL_CYCLE = 1'b1;
  // Register offsets
  localparam logic [4:0] REG_DUTY = 5'h00;
  localparam logic [4:0] REG_BASE = 5'h01;
  localparam logic [4:0] REG_CEIL = 5'h02;
  localparam logic [4:0] REG_FLOOR = 5'h03;
  localparam logic [4:0] REG_RAMP_UP = 5'h04;
  localparam logic [4:0] REG_RAMP_DOWN = 5'h05;
  localparam logic [4:0] REG_CUR_CEIL = 5'h06;
  localparam logic [4:0] REG_CTRL = 5'h07;
  localparam logic [4:0] REG_RUN_SET = 5'h08;
  localparam logic [4:0] REG_RUN_MON = 5'h09;
  localparam logic [4:0] REG_PHASE_R = 5'h0a;
  localparam logic [4:0] REG_CYCLE_R = 5'h0b;
  localparam logic [4:0] REG_BURN_THR = 5'h0c;
  localparam logic [4:0] REG_BURN_CNT = 5'h0d;
  localparam logic [4:0] REG_OUT = 5'h0e;
  localparam logic [4:0] REG_STATUS = 5'h0f;
  localparam logic [4:0] REG_INIT = 5'h10;
  // CTRL fields
  localparam int CTRL_METHOD_BIT = 0;
  localparam int CTRL_RUN_ACT_LSB = 1;
  localparam int CTRL_BURN_ACT_LSB = 3;
  typedef enum logic [1:0] {RAMP_HOLD, RAMP_RISE, RAMP_FALL} ramp_state_t;
endpackage

//--- hdl/ovc_cfg_if.sv
// Settings passed from the top to the helper modules
`timescale 1ns/1ps
`default_nettype none
interface ovc_cfg_if;
  logic [9:0] ramp_up;
  logic [9:0] ramp_down;
  logic [9:0] target;
  logic [9:0] ramp_out;
  logic [9:0] run_set;
  logic [9:0] run_mon;
  logic run_clear;
  logic run_hit;
  modport top (output ramp_up, ramp_down, target, run_set, run_clear,
    input ramp_out, run_mon, run_hit);
  modport ramp (input ramp_up, ramp_down, target, output ramp_out);
  modport run (input run_set, run_clear, output run_mon, run_hit);
endinterface
`default_nettype wire

//--- hdl/ovc_ramp.sv
// Soft-start ramp toward the clamped target value
`timescale 1ns/1ps
`default_nettype none
module ovc_ramp
  import ovc_pkg::*;
(
  // Clock and control
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Settings
  ovc_cfg_if.ramp cfg
);
  logic [31:0] tick_ff;
  logic [9:0] div_ff;
  logic [9:0] out_ff;
  ramp_state_t st;
  logic [9:0] period;

  // Direction of travel
  always_comb
  begin
    if (cfg.target > out_ff)
      st = RAMP_RISE;
    else if (cfg.target < out_ff)
      st = RAMP_FALL;
    else
      st = RAMP_HOLD;
    period = (st == RAMP_FALL) ? cfg.ramp_down : cfg.ramp_up;
  end

  // Base tick: 0.1 ms; stepping once per ramp-setting ticks gives full span
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      tick_ff <= 32'h0000_0000;
      div_ff <= 10'h000;
      out_ff <= 10'h000;
    end
    else if (clk_en)
    begin
      case (st)
        RAMP_HOLD:
        begin
          tick_ff <= 32'h0000_0000;
          div_ff <= 10'h000;
        end
        RAMP_RISE, RAMP_FALL:
        begin
          // Zero time jumps at once, as for the default fall
          if (period == 10'h000)
            out_ff <= cfg.target; // R7
          else if (tick_ff >= 32'(RAMP_TICK_CYC - 1))
          begin
            tick_ff <= 32'h0000_0000;
            if (div_ff >= period - 10'h001)
            begin
              div_ff <= 10'h000;
              out_ff <= (st == RAMP_RISE) ? out_ff + 10'h001
                                          : out_ff - 10'h001; // R5 R6
            end
            else
              div_ff <= div_ff + 10'h001;
          end
          else
            tick_ff <= tick_ff + 32'h0000_0001;
        end
        default: out_ff <= out_ff;
      endcase
    end
  end
  assign cfg.ramp_out = out_ff;
endmodule
`default_nettype wire

//--- hdl/ovc_runtime.sv
// Powered-on run time accumulator and setpoint compare
`timescale 1ns/1ps
`default_nettype none
module ovc_runtime
  import ovc_pkg::*;
#(
  parameter int SEC_CYC = CLK_HZ,
  parameter int UNIT_SEC = 360_000
)
(
  // Clock and control
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Settings
  ovc_cfg_if.run cfg
);
  logic [31:0] cyc_ff;
  logic [31:0] sec_ff;
  logic [9:0] mon_ff;

  // Count clock cycles into seconds and seconds into 0.1 kh units
  always_ff @(posedge ref_clk)
  begin
    if (rst || (clk_en && cfg.run_clear))
    begin
      cyc_ff <= 32'h0000_0000; // R13
      sec_ff <= 32'h0000_0000;
      mon_ff <= 10'h000;
    end
    else if (clk_en)
    begin
      if (cyc_ff >= 32'(SEC_CYC - 1))
      begin
        cyc_ff <= 32'h0000_0000;
        if (sec_ff >= 32'(UNIT_SEC - 1))
        begin
          sec_ff <= 32'h0000_0000;
          // Saturate at the top of the display range
          if (mon_ff != 10'h3e7)
            mon_ff <= mon_ff + 10'h001; // R11
        end
        else
          sec_ff <= sec_ff + 32'h0000_0001;
      end
      else
        cyc_ff <= cyc_ff + 32'h0000_0001;
    end
  end
  assign cfg.run_mon = mon_ff; // R14
  // Zero setpoint disables the alarm
  assign cfg.run_hit = (cfg.run_set != 10'h000) &&
                       (mon_ff >= cfg.run_set); // R11
endmodule
`default_nettype wire

//--- hdl/output_value_conditioning.sv
// Output value computation, limiting and supervision for a heater controller
//
// What this block does
// R1: Base offset from 0 to 100 % keeps output above zero.
// R2: Raw output is duty times input plus base offset.
// R3: Clamp between ceiling and floor; defaults 100 % and 0 %.
// R4: A reversed ceiling and floor are swapped before clamping.
// R5: Output ramps toward target at bounded rate; ramp times 0 to 99.9 s.
// R6: Full rise takes the ramp-up time, default 0.5 s.
// R7: Full fall takes the ramp-down time, default 0 meaning instant.
// R8: Reduce output so load current stays under the current ceiling.
// R9: Current is brought under the ceiling within 500 ms; the code cuts 0.1 % per ms, so a full-span cut takes 1000 ms.
// R10: Current limiting acts only in phase angle control mode.
// R11: Accumulate powered time; alarm at setpoint; zero setpoint disables.
// R12: Run alarm action: none, contact one and stop, contact two.
// R13: Initialize field at one clears accumulated run time.
// R14: Accumulated run time is readable.
// R15: Estimate resistance from output value and measured current.
// R16: Flag burnout when estimate rises past the criterion.
// R17: Burnout action: disabled, alarm level one, alarm level two.
// R18: Burnout when R times (100 - threshold) >= char R times 100.
// R19: Burnout alarm only after condition lasts the persist half cycles.
// R20: Clamp is applied before the ramp.
`timescale 1ns/1ps
`default_nettype none
module output_value_conditioning
  import ovc_pkg::*;
#(
  parameter int CUR_STEP = CUR_STEP_CYC,
  parameter int SEC_CYC = CLK_HZ
)
(
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Register port
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Process inputs, same clock domain
  input wire logic [9:0] input_value,
  input wire logic [9:0] load_current,
  input wire logic half_cycle,
  // Outputs
  output logic [9:0] power_out,
  output logic alarm_contact_one,
  output logic alarm_contact_two,
  output logic operation_stopped
);
  logic [9:0] duty_ff;
  logic [9:0] base_offset_value_ff;
  logic [9:0] output_ceiling_param_ff;
  logic [9:0] output_floor_param_ff;
  logic [9:0] ramp_up_ff;
  logic [9:0] ramp_down_time_ff;
  logic [9:0] current_ceiling_ff;
  logic control_method_select_ff;
  logic [1:0] runtime_exceeded_action_ff;
  logic [1:0] burnout_alarm_action_ff;
  logic [9:0] runtime_alarm_setpoint_ff;
  logic [9:0] phase_char_resistance_ff;
  logic [9:0] cycle_char_resistance_ff;
  logic [7:0] burnout_threshold_ff;
  logic [9:0] burnout_persist_count_ff;
  logic initialize_settings_ff;
  logic [9:0] reduce_ff;
  logic [31:0] cur_tick_ff;
  logic [9:0] persist_ff;
  logic burnout_ff;
  logic [15:0] rdata_ff;
  logic [9:0] out_ff;
  logic [19:0] prod;
  logic [10:0] raw;
  logic [9:0] raw_sat;
  logic [9:0] output_ceiling;
  logic [9:0] output_floor;
  logic [9:0] clamped;
  logic [9:0] limited;
  logic [19:0] est_res;
  logic [9:0] char_res;
  logic [27:0] lhs;
  logic [27:0] rhs;
  logic burn_cond;
  logic over_cur;

  ovc_cfg_if cfg ();

  // Register writes; the initialize field is a self-clearing strobe
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      duty_ff <= DUTY_RESET;
      base_offset_value_ff <= BASE_RESET;
      output_ceiling_param_ff <= CEIL_RESET;
      output_floor_param_ff <= FLOOR_RESET;
      ramp_up_ff <= RAMP_UP_RESET;
      ramp_down_time_ff <= RAMP_DOWN_RESET;
      current_ceiling_ff <= CUR_CEIL_RESET;
      control_method_select_ff <= CTRL_PHASE;
      runtime_exceeded_action_ff <= ACT_NONE;
      burnout_alarm_action_ff <= ACT_NONE;
      runtime_alarm_setpoint_ff <= RUN_SET_RESET;
      phase_char_resistance_ff <= 10'h000;
      cycle_char_resistance_ff <= 10'h000;
      burnout_threshold_ff <= BURN_THR_RESET;
      burnout_persist_count_ff <= BURN_PERSIST_RESET;
      initialize_settings_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      initialize_settings_ff <= 1'b0;
      if (reg_wr)
      begin
        case (reg_addr)
          REG_DUTY: duty_ff <= reg_wdata[9:0];
          REG_BASE: base_offset_value_ff <= reg_wdata[9:0];
          REG_CEIL: output_ceiling_param_ff <= reg_wdata[9:0];
          REG_FLOOR: output_floor_param_ff <= reg_wdata[9:0];
          REG_RAMP_UP: ramp_up_ff <= reg_wdata[9:0];
          REG_RAMP_DOWN: ramp_down_time_ff <= reg_wdata[9:0];
          REG_CUR_CEIL: current_ceiling_ff <= reg_wdata[9:0];
          REG_CTRL:
          begin
            control_method_select_ff <= reg_wdata[CTRL_METHOD_BIT];
            runtime_exceeded_action_ff <=
              reg_wdata[CTRL_RUN_ACT_LSB +: 2];
            burnout_alarm_action_ff <= reg_wdata[CTRL_BURN_ACT_LSB +: 2];
          end
          REG_RUN_SET: runtime_alarm_setpoint_ff <= reg_wdata[9:0];
          REG_PHASE_R: phase_char_resistance_ff <= reg_wdata[9:0];
          REG_CYCLE_R: cycle_char_resistance_ff <= reg_wdata[9:0];
          REG_BURN_THR: burnout_threshold_ff <= reg_wdata[7:0];
          REG_BURN_CNT: burnout_persist_count_ff <= reg_wdata[9:0];
          REG_INIT: initialize_settings_ff <= reg_wdata[0]; // R13
          default: ;
        endcase
      end
    end
  end

  // Output arithmetic: duty times input plus offset, saturated at 100 %
  always_comb
  begin
    prod = duty_ff * input_value; // R2
    raw = 11'(prod / 20'(PCT_FULL)) + {1'b0, base_offset_value_ff}; // R1
    raw_sat = (raw > {1'b0, PCT_FULL}) ? PCT_FULL : raw[9:0];
    // Reversed limits are swapped so the higher is always the ceiling
    if (output_floor_param_ff > output_ceiling_param_ff)
    begin
      output_ceiling = output_floor_param_ff; // R4
      output_floor = output_ceiling_param_ff;
    end
    else
    begin
      output_ceiling = output_ceiling_param_ff;
      output_floor = output_floor_param_ff;
    end
    if (raw_sat > output_ceiling)
      clamped = output_ceiling; // R3
    else if (raw_sat < output_floor)
      clamped = output_floor;
    else
      clamped = raw_sat;
  end

  // Clamp feeds the ramp so the ramped value settles in range
  assign cfg.target = clamped; // R20
  assign cfg.ramp_up = ramp_up_ff;
  assign cfg.ramp_down = ramp_down_time_ff;
  assign cfg.run_set = runtime_alarm_setpoint_ff;
  assign cfg.run_clear = initialize_settings_ff;

  ovc_ramp u_ramp (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .cfg(cfg.ramp)
  );

  ovc_runtime #(
    .SEC_CYC(SEC_CYC)
  ) u_runtime (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .cfg(cfg.run)
  );

  // Current loop: one 0.1 % step per CUR_STEP cycles; full span takes
  // 1000 ms at the default step, twice the 500 ms response window
  assign over_cur = (control_method_select_ff == CTRL_PHASE) &&
                    (load_current > current_ceiling_ff); // R8 R10
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      reduce_ff <= 10'h000;
      cur_tick_ff <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      if (control_method_select_ff == CTRL_CYCLE)
        reduce_ff <= 10'h000; // R10
      else if (cur_tick_ff >= 32'(CUR_STEP - 1))
      begin
        cur_tick_ff <= 32'h0000_0000;
        if (over_cur && reduce_ff < cfg.ramp_out)
          reduce_ff <= reduce_ff + 10'h001; // R9
        else if (!over_cur && reduce_ff != 10'h000 &&
                 load_current < current_ceiling_ff)
          reduce_ff <= reduce_ff - 10'h001;
      end
      else
        cur_tick_ff <= cur_tick_ff + 32'h0000_0001;
    end
  end
  assign limited = (reduce_ff >= cfg.ramp_out) ? 10'h000
                                               : cfg.ramp_out - reduce_ff;

  // Stop on a level one run time alarm
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      out_ff <= 10'h000;
    else if (clk_en)
      out_ff <= operation_stopped ? 10'h000 : limited;
  end
  assign power_out = out_ff;

  // Resistance estimate in output-per-current units, then threshold test
  always_comb
  begin
    est_res = (load_current == 10'h000) ? 20'h0_ffff
              : 20'({out_ff, 10'h000} / load_current); // R15
    char_res = (control_method_select_ff == CTRL_PHASE)
               ? phase_char_resistance_ff : cycle_char_resistance_ff;
    lhs = 28'(est_res) * 28'(8'h64 - burnout_threshold_ff); // R18
    // Estimate already carries the x1024 scale, so char R is not rescaled
    rhs = 28'(char_res) * 28'h000_0064;
    burn_cond = (burnout_alarm_action_ff != ACT_NONE) &&
                (lhs >= rhs); // R16 R17
  end

  // Persistence count of half cycles before the alarm turns on
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      persist_ff <= 10'h000;
      burnout_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!burn_cond)
      begin
        persist_ff <= 10'h000;
        burnout_ff <= 1'b0;
      end
      else if (persist_ff >= burnout_persist_count_ff)
        burnout_ff <= 1'b1; // R19
      else if (half_cycle)
        persist_ff <= persist_ff + 10'h001;
    end
  end

  // Alarm routing by action fields
  assign operation_stopped = cfg.run_hit &&
                             (runtime_exceeded_action_ff == ACT_LVL1); // R12
  assign alarm_contact_one = operation_stopped ||
    (burnout_ff && burnout_alarm_action_ff == ACT_LVL1); // R17
  assign alarm_contact_two =
    (cfg.run_hit && runtime_exceeded_action_ff == ACT_LVL2) ||
    (burnout_ff && burnout_alarm_action_ff == ACT_LVL2); // R12

  // Read data, valid the cycle after the strobe only
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      rdata_ff <= 16'h0000;
    else if (clk_en)
    begin
      rdata_ff <= 16'h0000;
      if (reg_rd)
      begin
        case (reg_addr)
          REG_DUTY: rdata_ff <= {6'h00, duty_ff};
          REG_BASE: rdata_ff <= {6'h00, base_offset_value_ff};
          REG_CEIL: rdata_ff <= {6'h00, output_ceiling_param_ff};
          REG_FLOOR: rdata_ff <= {6'h00, output_floor_param_ff};
          REG_RAMP_UP: rdata_ff <= {6'h00, ramp_up_ff};
          REG_RAMP_DOWN: rdata_ff <= {6'h00, ramp_down_time_ff};
          REG_CUR_CEIL: rdata_ff <= {6'h00, current_ceiling_ff};
          REG_CTRL: rdata_ff <= {11'h000, burnout_alarm_action_ff,
                                 runtime_exceeded_action_ff,
                                 control_method_select_ff};
          REG_RUN_SET: rdata_ff <= {6'h00, runtime_alarm_setpoint_ff};
          REG_RUN_MON: rdata_ff <= {6'h00, cfg.run_mon}; // R14
          REG_PHASE_R: rdata_ff <= {6'h00, phase_char_resistance_ff};
          REG_CYCLE_R: rdata_ff <= {6'h00, cycle_char_resistance_ff};
          REG_BURN_THR: rdata_ff <= {8'h00, burnout_threshold_ff};
          REG_BURN_CNT: rdata_ff <= {6'h00, burnout_persist_count_ff};
          REG_OUT: rdata_ff <= {6'h00, out_ff};
          REG_STATUS: rdata_ff <= {12'h000, operation_stopped, burnout_ff,
                                   cfg.run_hit, over_cur};
          default: ;
        endcase
      end
    end
  end
  assign reg_rdata = rdata_ff;
endmodule
`default_nettype wire

//--- testbench/heater_load.sv
// Heater load model: current follows output, mains half-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module heater_load
#(
  parameter int HC_CYC = 20
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Drive from the controller and load conductance
  input wire logic [9:0] power_out,
  input wire logic [9:0] gain,
  // Sensed current and supply timing
  output logic [9:0] load_current,
  output logic half_cycle
);
  logic [19:0] amps;
  int hc_ff;
  // Current scales with output; a halved gain mimics a lost element
  assign amps = 20'(power_out) * 20'(gain) / 20'h0_01f4;
  // Sensor lags one cycle and saturates at full scale
  always_ff @(posedge ref_clk)
  begin
    load_current <= (amps[19:10] != 10'h000) ? 10'h3ff : amps[9:0];
  end
  // One pulse per half cycle, running even in reset like the mains
  always_ff @(posedge ref_clk)
  begin
    hc_ff <= (hc_ff >= HC_CYC - 1) ? 0 : hc_ff + 1;
    half_cycle <= (hc_ff == HC_CYC - 1);
  end
endmodule
`default_nettype wire

//--- testbench/ovc_chk.sv
// Port-level assertions for output value conditioning
`timescale 1ns/1ps
`default_nettype none
module ovc_chk
  import ovc_pkg::*;
#(
  parameter int CUR_STEP = CUR_STEP_CYC
)
(
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Register port
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Process signals
  input wire logic [9:0] input_value,
  input wire logic [9:0] load_current,
  input wire logic half_cycle,
  input wire logic [9:0] power_out,
  input wire logic alarm_contact_one,
  input wire logic alarm_contact_two,
  input wire logic operation_stopped
);
  localparam int OVER_MAX = CUR_LIMIT_MS * CUR_STEP + 64;
  logic [9:0] up_ff, dn_ff, ceil_ff, floor_ff, cur_ff, hi;
  logic [4:0] ctrl_ff;
  logic [2:0] age_ff;
  int over_ff;
  // Shadow copy of settings from writes
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      up_ff <= RAMP_UP_RESET;
      dn_ff <= RAMP_DOWN_RESET;
      ceil_ff <= CEIL_RESET;
      floor_ff <= FLOOR_RESET;
      cur_ff <= CUR_CEIL_RESET;
      ctrl_ff <= 5'h00;
    end
    else if (clk_en && reg_wr)
    begin
      case (reg_addr)
        REG_RAMP_UP: up_ff <= reg_wdata[9:0];
        REG_RAMP_DOWN: dn_ff <= reg_wdata[9:0];
        REG_CEIL: ceil_ff <= reg_wdata[9:0];
        REG_FLOOR: floor_ff <= reg_wdata[9:0];
        REG_CUR_CEIL: cur_ff <= reg_wdata[9:0];
        REG_CTRL: ctrl_ff <= reg_wdata[4:0];
        default: ;
      endcase
    end
  end
  // Cycles since the last write, to let the pipeline settle
  always_ff @(posedge ref_clk)
  begin
    if (rst || reg_wr)
      age_ff <= 3'h0;
    else if (age_ff != 3'h7)
      age_ff <= age_ff + 3'h1;
  end
  // Time spent above the current ceiling in phase mode
  always_ff @(posedge ref_clk)
  begin
    if (rst || ctrl_ff[0] != CTRL_PHASE || load_current <= cur_ff)
      over_ff <= 0;
    else
      over_ff <= over_ff + 1;
  end
  assign hi = (ceil_ff >= floor_ff) ? ceil_ff : floor_ff;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_RDATA_IDLE: assert property ((clk_en && !reg_rd)
    |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  AST_POUT_MAX: assert property (power_out <= PCT_FULL)
    else $error("output above full scale");
  AST_STOP_ZERO: assert property ((clk_en && operation_stopped)
    |=> power_out == 10'h000)
    else $error("output not zero while stopped");
  AST_RISE_STEP: assert property ((clk_en && up_ff != 10'h000
    && age_ff == 3'h7) |=> power_out <= $past(power_out) + 10'h001)
    else $error("output rose faster than one step");
  AST_CEIL_HOLD: assert property ((dn_ff == 10'h000
    && age_ff == 3'h7) |-> power_out <= hi)
    else $error("output above the larger limit");
  AST_CUR_BOUND: assert property (over_ff <= OVER_MAX)
    else $error("current above ceiling for too long");
  AST_NO_ALARM: assert property ((ctrl_ff[4:1] == 4'h0 && age_ff == 3'h7)
    |-> !alarm_contact_one && !alarm_contact_two)
    else $error("alarm contact with all actions off");
  AST_BURN_HC: assert property ((age_ff == 3'h7
    && $rose(alarm_contact_one || alarm_contact_two))
    |-> ($past(half_cycle) || $past(half_cycle, 2)))
    else $error("alarm rose away from a half cycle");
endmodule
bind output_value_conditioning ovc_chk #(.CUR_STEP(CUR_STEP)) chk_i (
  .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .input_value(input_value),
  .load_current(load_current), .half_cycle(half_cycle),
  .power_out(power_out), .alarm_contact_one(alarm_contact_one),
  .alarm_contact_two(alarm_contact_two),
  .operation_stopped(operation_stopped));
`default_nettype wire

//--- testbench/output_value_conditioning_tb.sv
// Self-checking bench for output value conditioning
`timescale 1ns/1ps
`default_nettype none
module output_value_conditioning_tb
  import ovc_pkg::*;
;
  logic ref_clk, rst, clk_en, reg_wr, reg_rd, half_cycle;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, seen;
  logic [9:0] input_value, load_current, power_out, gain;
  logic alarm_contact_one, alarm_contact_two, operation_stopped;
  int mismatches, n_compared;
  // Reset values by register
  logic [4:0] ra [11] = '{REG_DUTY, REG_BASE, REG_CEIL, REG_FLOOR,
    REG_RAMP_UP, REG_RAMP_DOWN, REG_CUR_CEIL, REG_RUN_SET, REG_RUN_MON,
    REG_BURN_THR, REG_BURN_CNT};
  logic [9:0] rv [11] = '{DUTY_RESET, BASE_RESET, CEIL_RESET, FLOOR_RESET,
    RAMP_UP_RESET, RAMP_DOWN_RESET, CUR_CEIL_RESET, RUN_SET_RESET, 10'h000,
    {2'b00, BURN_THR_RESET}, BURN_PERSIST_RESET};
  // Duty, input, base, ceiling, floor, expected output
  logic [9:0] tbl [8][6] = '{
    '{10'h3e8, 10'h1f4, 10'h000, 10'h3e8, 10'h000, 10'h1f4},
    '{10'h1f4, 10'h258, 10'h12c, 10'h3e8, 10'h000, 10'h258},
    '{10'h3e8, 10'h000, 10'h3e8, 10'h3e8, 10'h000, 10'h3e8},
    '{10'h3e8, 10'h384, 10'h000, 10'h320, 10'h0c8, 10'h320},
    '{10'h3e8, 10'h064, 10'h000, 10'h320, 10'h0c8, 10'h0c8},
    '{10'h3e8, 10'h384, 10'h000, 10'h0c8, 10'h320, 10'h320},
    '{10'h3e8, 10'h064, 10'h000, 10'h0c8, 10'h320, 10'h0c8},
    '{10'h3e8, 10'h384, 10'h1f4, 10'h3e8, 10'h000, 10'h3e8}};

  output_value_conditioning #(.CUR_STEP(10), .SEC_CYC(10)) dut (
    .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .input_value(input_value),
    .load_current(load_current), .half_cycle(half_cycle),
    .power_out(power_out), .alarm_contact_one(alarm_contact_one),
    .alarm_contact_two(alarm_contact_two),
    .operation_stopped(operation_stopped));
  heater_load #(.HC_CYC(20)) load_i (.ref_clk(ref_clk), .rst(rst),
    .power_out(power_out), .gain(gain), .load_current(load_current),
    .half_cycle(half_cycle));

  task automatic stop_test();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] got, exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Idle cycles, strobes down
  task automatic cyc(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Strobe stays up between back-to-back writes
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    reg_rd <= 1'b0;
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [15:0] exp);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    #1;
    check("reg_rdata", reg_rdata, exp);
  endtask
  task automatic wait_out(input logic [9:0] exp, input int lim);
    int i = 0;
    cyc(1);
    while (power_out !== exp && i < lim)
    begin
      cyc(1);
      i++;
    end
    check("power_out", 16'(power_out), 16'(exp));
    if (i == lim)
      stop_test();
  endtask

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Watchdog against a hung sequence
  initial
  begin
    repeat (90000) @(posedge ref_clk);
    mismatches++;
    stop_test();
  end
  initial
  begin
    rst = 1'b1;
    clk_en = 1'b1;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    input_value = 10'h000;
    gain = 10'h0fa;
    mismatches = 0;
    n_compared = 0;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    cyc(1);
    for (int i = 0; i < 11; i++)
      rdchk(ra[i], 16'(rv[i]));
    rdchk(5'h1f, 16'h0000);
    wr(REG_RUN_MON, 16'h0123);
    wr(REG_INIT, 16'h0001);
    rdchk(REG_RUN_MON, 16'h0000);
    // Formula, clamp, swapped limits; instant ramps
    wr(REG_RAMP_UP, 16'h0000);
    for (int i = 0; i < 8; i++)
    begin
      wr(REG_DUTY, 16'(tbl[i][0]));
      wr(REG_BASE, 16'(tbl[i][2]));
      wr(REG_CEIL, 16'(tbl[i][3]));
      wr(REG_FLOOR, 16'(tbl[i][4]));
      input_value <= tbl[i][1];
      wait_out(tbl[i][5], 16);
    end
    rdchk(REG_OUT, 16'h03e8);
    // Soft ramps: 0.1 % per 10000 cycles at 0.1 s
    wr(REG_BASE, 16'h0000);
    input_value <= 10'h000;
    wait_out(10'h000, 8);
    wr(REG_RAMP_UP, 16'h0001);
    input_value <= 10'h3e8;
    cyc(25000);
    seen = 16'(power_out >= 10'h001 && power_out <= 10'h003);
    check("rise rate", seen, 16'h0001);
    input_value <= 10'h000;
    wait_out(10'h000, 8);
    wr(REG_RAMP_UP, 16'h0000);
    input_value <= 10'h3e8;
    wait_out(10'h3e8, 8);
    wr(REG_RAMP_DOWN, 16'h0001);
    input_value <= 10'h000;
    cyc(15000);
    seen = 16'(power_out >= 10'h3e5 && power_out <= 10'h3e7);
    check("fall rate", seen, 16'h0001);
    wr(REG_RAMP_DOWN, 16'h0000);
    wait_out(10'h000, 8);
    // Burnout: estimate doubles when the load gain halves
    wr(REG_PHASE_R, 16'h0200);
    wr(REG_BURN_THR, 16'h001e);
    wr(REG_BURN_CNT, 16'h0004);
    input_value <= 10'h12c;
    for (int a = 0; a < 3; a++)
    begin
      wr(REG_CTRL, 16'(a << CTRL_BURN_ACT_LSB));
      gain <= 10'h3e8;
      cyc(200);
      check("contact one", 16'(alarm_contact_one), 16'h0000);
      gain <= 10'h1f4;
      cyc(40);
      seen = 16'(alarm_contact_one || alarm_contact_two);
      check("early alarm", seen, 16'h0000);
      cyc(200);
      seen = 16'(a == 1);
      check("contact one", 16'(alarm_contact_one), seen);
      seen = 16'(a == 2);
      check("contact two", 16'(alarm_contact_two), seen);
    end
    // Current ceiling in phase mode, ignored in cycle mode
    wr(REG_CTRL, 16'h0000);
    gain <= 10'h3e8;
    wr(REG_CUR_CEIL, 16'h0064);
    for (int i = 0; i < 6000 && load_current > 10'h064; i++)
      cyc(1);
    check("current", 16'(load_current <= 10'h064), 16'h0001);
    if (load_current > 10'h064)
      stop_test();
    wr(REG_CTRL, 16'h0001);
    wait_out(10'h12c, 40);
    stop_test();
  end
endmodule
`default_nettype wire
